// ---- dv/hdlcr_regs_tb.sv ----
`timescale 1ns/1ps
module hdlcr_regs_tb;
  import hdlcr_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  hdlcr_reg_req_t reg_req = '0;
  hdlcr_cal_res_t cal_res = '0;
  logic closed_loop = 1'b0;
  logic [7:0] audio_input_floor = 8'h00;
  logic [7:0] audio_level = 8'h00;
  logic [7:0] od_request = 8'h00;
  logic [7:0] gain_in = 8'h00;
  logic [7:0] reg_rdata, audio_drive_out, full_scale_ref, od_drive_out;
  logic [7:0] cal_nominal_level, feedback_bemf_level;
  logic [8:0] gain_out;
  logic [31:0] r;
  int mdl [19:25];
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  hdlcr_regs DUT (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .closed_loop(closed_loop), .cal_res(cal_res),
    .audio_input_floor(audio_input_floor), .audio_level(audio_level),
    .od_request(od_request), .gain_in(gain_in),
    .audio_drive_out(audio_drive_out), .full_scale_ref(full_scale_ref),
    .od_drive_out(od_drive_out), .gain_out(gain_out),
    .cal_nominal_level(cal_nominal_level),
    .feedback_bemf_level(feedback_bemf_level));

  always #5 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_req.wr = 1'b0;
    if (a >= 8'h13 && a <= 8'h19)
      mdl[a] = d;
    @(posedge mclk);
    #1;
  endtask : wr

  task automatic mdl_init;
    mdl = '{RST_INPUT_FULL_SCALE, RST_DRIVE_FLOOR, RST_DRIVE_CEILING,
      RST_MOTOR_NOMINAL, RST_OVERDRIVE_LIMIT, RST_LOSS_COMP, RST_BACKEMF_LEVEL};
  endtask : mdl_init

  task automatic rd(input logic [7:0] a);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_req.rd = 1'b0;
    @(posedge mclk);
    #1;
    chk({1'b0, reg_rdata}, (a >= 8'h13 && a <= 8'h19) ? 9'(mdl[a]) : 9'h000);
  endtask : rd

  function automatic int amap(int lv, int inf);
    int fs = mdl[19];
    int fl = mdl[20];
    int ce = mdl[21];
    if (lv < inf)
      return 0;
    if (ce <= fl)
      return fl;
    if (lv >= fs || fs <= inf)
      return ce;
    return fl + (lv - inf) * (ce - fl) / (fs - inf);
  endfunction : amap

  initial
  begin
    int lim;
    void'($urandom(38528));
    mdl_init();
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int a = 8'h12; a <= 8'h1A; a++) rd(8'(a));
    chk({1'b0, cal_nominal_level}, 9'h03E);
    chk({1'b0, feedback_bemf_level}, 9'h06F);
    for (int a = 8'h12; a <= 8'h1A; a++) wr(8'(a), 8'($urandom));
    for (int a = 8'h12; a <= 8'h1A; a++) rd(8'(a));
    repeat (6)
    begin
      for (int a = 8'h13; a <= 8'h18; a++) wr(8'(a), 8'($urandom));
      chk({1'b0, cal_nominal_level}, 9'(mdl[22]));
      repeat (40)
      begin
        r = $urandom;
        closed_loop = r[0];
        audio_level = r[8:1];
        od_request = r[16:9];
        gain_in = r[24:17];
        audio_input_floor = {r[31:26], 2'b00};
        @(posedge mclk);
        #1;
        lim = mdl[23];
        chk({1'b0, full_scale_ref}, 9'(closed_loop ? mdl[22] : lim));
        chk({1'b0, od_drive_out}, 9'((closed_loop && od_request > lim) ?
          lim : od_request));
        chk(gain_out, 9'(gain_in * (255 + mdl[24]) / 255));
        chk({1'b0, audio_drive_out},
          9'(amap(audio_level, audio_input_floor)));
      end
    end
    repeat (3)
    begin
      wr(8'h16, 8'($urandom));
      r = $urandom;
      cal_res = {1'b1, r[7:0], r[15:8]};
      reg_req.addr = 8'h18;
      reg_req.wdata = r[23:16];
      reg_req.wr = 1'b1;
      @(posedge mclk);
      #1;
      cal_res.done = 1'b0;
      reg_req.wr = 1'b0;
      mdl[24] = r[7:1];
      mdl[25] = r[15:8];
      rd(8'h18);
      rd(8'h19);
      chk({1'b0, feedback_bemf_level}, 9'(mdl[25]));
    end
    // Second reset in mid-run
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({1'b0, full_scale_ref}, 9'h03E);
    chk(gain_out, 9'h000);
    rst_n = 1'b1;
    mdl_init();
    for (int a = 8'h13; a <= 8'h19; a++) rd(8'(a));
    end_of_test();
  end
endmodule : hdlcr_regs_tb

// ---- hdl/hdlcr_pkg.sv ----
package hdlcr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_INPUT_FULL_SCALE = 8'h13;
  localparam logic [7:0] ADDR_DRIVE_FLOOR = 8'h14;
  localparam logic [7:0] ADDR_DRIVE_CEILING = 8'h15;
  localparam logic [7:0] ADDR_MOTOR_NOMINAL = 8'h16;
  localparam logic [7:0] ADDR_OVERDRIVE_LIMIT = 8'h17;
  localparam logic [7:0] ADDR_LOSS_COMP = 8'h18;
  localparam logic [7:0] ADDR_BACKEMF_LEVEL = 8'h19;
  // Reset values
  localparam logic [7:0] RST_INPUT_FULL_SCALE = 8'hFF;
  localparam logic [7:0] RST_DRIVE_FLOOR = 8'h19;
  localparam logic [7:0] RST_DRIVE_CEILING = 8'hFF;
  localparam logic [7:0] RST_MOTOR_NOMINAL = 8'h3E;
  localparam logic [7:0] RST_OVERDRIVE_LIMIT = 8'h8C;
  localparam logic [7:0] RST_LOSS_COMP = 8'h0C;
  localparam logic [7:0] RST_BACKEMF_LEVEL = 8'h6F;
  // Unmapped read answer
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Code that stands for unity (full scale)
  localparam logic [16:0] CODE_FULL = 17'h000FF;
  // Impedance code to compensation code shift
  localparam int LOSS_SHIFT = 1;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hdlcr_reg_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] impedance;
    logic [7:0] backemf;
  } hdlcr_cal_res_t;
endpackage : hdlcr_pkg

// ---- hdl/hdlcr_regs.sv ----
`timescale 1ns/1ps
// Contract
// - The input full-scale register holds the input level taken as full scale, reset 0xFF.
// - The drive floor register sets the lowest audio drive level, reset 0x19.
// - The drive ceiling register sets the highest audio drive level, reset 0xFF.
// - The motor nominal level register is the closed-loop full-scale reference, reset 0x3E.
// - Calibration reads the motor nominal level, which the host loads before starting.
// - In open loop the nominal level is ignored and the overdrive limit is used.
// - In closed loop automatic overdrive is clamped to the overdrive limit, reset 0x8C.
// - In open loop the overdrive limit is the full-scale reference.
// - Calibration completion writes the loss compensation register, reset 0x0C.
// - The compensation value is derived from the measured actuator impedance.
// - Playback gain is multiplied by one plus the compensation code over 255.
// - The back-EMF register, reset 0x6F, takes the calibration result and steers feedback gain.
module hdlcr_regs
(
  input wire logic mclk, // Device clock
  input wire logic rst_n, // Async reset, active low
  input wire hdlcr_pkg::hdlcr_reg_req_t reg_req, // Register access
  output logic [7:0] reg_rdata, // Read data, one cycle after rd
  input wire logic closed_loop, // 1 closed loop, 0 open loop
  input wire hdlcr_pkg::hdlcr_cal_res_t cal_res, // Calibration result
  input wire logic [7:0] audio_input_floor, // Minimum input level code
  input wire logic [7:0] audio_level, // Detected input level
  input wire logic [7:0] od_request, // Requested overdrive level
  input wire logic [7:0] gain_in, // Drive gain before compensation
  output logic [7:0] audio_drive_out, // Mapped audio drive level
  output logic [7:0] full_scale_ref, // Active full-scale reference
  output logic [7:0] od_drive_out, // Clamped overdrive level
  output logic [8:0] gain_out, // Compensated drive gain
  output logic [7:0] cal_nominal_level, // Nominal level for calibration
  output logic [7:0] feedback_bemf_level // Back-EMF level for feedback
);
  import hdlcr_pkg::*;

  logic [7:0] audio_input_full_scale_reg;
  logic [7:0] audio_drive_floor_reg;
  logic [7:0] audio_drive_ceiling_reg;
  logic [7:0] motor_nominal_level_reg;
  logic [7:0] overdrive_limit_reg;
  logic [7:0] calib_loss_compensation_reg;
  logic [7:0] calib_backemf_level_reg;
  logic [7:0] rdata_next;
  logic [7:0] loss_comp_next;
  logic [7:0] audio_drive_next;
  logic [8:0] gain_next;
  logic [16:0] gain_product;
  logic [15:0] span_product;
  logic [7:0] span_in;
  logic [7:0] span_out;

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = reg_req.wr && (reg_req.addr == a);
  endfunction : wr_hit

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      audio_input_full_scale_reg <= RST_INPUT_FULL_SCALE;
    else if (wr_hit(ADDR_INPUT_FULL_SCALE))
      audio_input_full_scale_reg <= reg_req.wdata;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      audio_drive_floor_reg <= RST_DRIVE_FLOOR;
      audio_drive_ceiling_reg <= RST_DRIVE_CEILING;
    end
    else
    begin
      if (wr_hit(ADDR_DRIVE_FLOOR))
        audio_drive_floor_reg <= reg_req.wdata;
      if (wr_hit(ADDR_DRIVE_CEILING))
        audio_drive_ceiling_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      motor_nominal_level_reg <= RST_MOTOR_NOMINAL;
    else if (wr_hit(ADDR_MOTOR_NOMINAL))
      motor_nominal_level_reg <= reg_req.wdata;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      overdrive_limit_reg <= RST_OVERDRIVE_LIMIT;
    else if (wr_hit(ADDR_OVERDRIVE_LIMIT))
      overdrive_limit_reg <= reg_req.wdata;
  end

  // Compensation from impedance; larger load loss, larger code
  assign loss_comp_next = cal_res.impedance >> LOSS_SHIFT;

  // Calibration result wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calib_loss_compensation_reg <= RST_LOSS_COMP;
      calib_backemf_level_reg <= RST_BACKEMF_LEVEL;
    end
    else if (cal_res.done)
    begin
      calib_loss_compensation_reg <= loss_comp_next;
      calib_backemf_level_reg <= cal_res.backemf;
    end
    else
    begin
      if (wr_hit(ADDR_LOSS_COMP))
        calib_loss_compensation_reg <= reg_req.wdata;
      if (wr_hit(ADDR_BACKEMF_LEVEL))
        calib_backemf_level_reg <= reg_req.wdata;
    end
  end

  always_comb
  begin
    if (reg_req.addr == ADDR_INPUT_FULL_SCALE)
      rdata_next = audio_input_full_scale_reg;
    else if (reg_req.addr == ADDR_DRIVE_FLOOR)
      rdata_next = audio_drive_floor_reg;
    else if (reg_req.addr == ADDR_DRIVE_CEILING)
      rdata_next = audio_drive_ceiling_reg;
    else if (reg_req.addr == ADDR_MOTOR_NOMINAL)
      rdata_next = motor_nominal_level_reg;
    else if (reg_req.addr == ADDR_OVERDRIVE_LIMIT)
      rdata_next = overdrive_limit_reg;
    else if (reg_req.addr == ADDR_LOSS_COMP)
      rdata_next = calib_loss_compensation_reg;
    else if (reg_req.addr == ADDR_BACKEMF_LEVEL)
      rdata_next = calib_backemf_level_reg;
    else
      rdata_next = READ_UNMAPPED;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= READ_UNMAPPED;
    else if (reg_req.rd)
      reg_rdata <= rdata_next;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      full_scale_ref <= RST_MOTOR_NOMINAL;
    else if (closed_loop)
      full_scale_ref <= motor_nominal_level_reg;
    else
      full_scale_ref <= overdrive_limit_reg;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      od_drive_out <= 8'h00;
    else if (closed_loop && (od_request > overdrive_limit_reg))
      od_drive_out <= overdrive_limit_reg;
    else
      od_drive_out <= od_request;
  end

  // Calibration and feedback see the live register values
  assign cal_nominal_level = motor_nominal_level_reg;
  assign feedback_bemf_level = calib_backemf_level_reg;

  assign gain_product = 17'(gain_in) *
    (CODE_FULL + 17'(calib_loss_compensation_reg));
  assign gain_next = 9'(gain_product / CODE_FULL);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      gain_out <= 9'h000;
    else
      gain_out <= gain_next;
  end

  // Below the input floor the level is ignored
  assign span_in = audio_input_full_scale_reg - audio_input_floor;
  assign span_out = audio_drive_ceiling_reg - audio_drive_floor_reg;
  assign span_product = 16'(audio_level - audio_input_floor) *
    16'(span_out);

  always_comb
  begin
    if (audio_level < audio_input_floor)
      audio_drive_next = 8'h00;
    else if (audio_drive_ceiling_reg <= audio_drive_floor_reg)
      audio_drive_next = audio_drive_floor_reg;
    else if (audio_level >= audio_input_full_scale_reg ||
             span_in == 8'h00)
      audio_drive_next = audio_drive_ceiling_reg;
    else
      audio_drive_next = audio_drive_floor_reg +
        8'(span_product / 16'(span_in));
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      audio_drive_out <= 8'h00;
    else
      audio_drive_out <= audio_drive_next;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_FS_WRITE: assert property (
    wr_hit(ADDR_INPUT_FULL_SCALE) |=>
      audio_input_full_scale_reg == $past(reg_req.wdata))
    else $error("full scale write lost");
  AST_DRIVE_RANGE: assert property (
    (audio_level >= audio_input_floor &&
     audio_drive_floor_reg < audio_drive_ceiling_reg) ##1
    $stable(audio_drive_floor_reg) && $stable(audio_drive_ceiling_reg) |->
      audio_drive_out >= audio_drive_floor_reg &&
      audio_drive_out <= audio_drive_ceiling_reg)
    else $error("audio drive outside floor and ceiling");
  AST_CEIL_TOP: assert property (
    (audio_level >= audio_input_full_scale_reg &&
     audio_level >= audio_input_floor &&
     audio_drive_floor_reg < audio_drive_ceiling_reg) |=>
      audio_drive_out == $past(audio_drive_ceiling_reg))
    else $error("full scale input not at ceiling");
  AST_REF_CLOSED: assert property (
    closed_loop |=> full_scale_ref == $past(motor_nominal_level_reg))
    else $error("closed loop reference wrong");
  AST_REF_OPEN: assert property (
    !closed_loop |=> full_scale_ref == $past(overdrive_limit_reg))
    else $error("open loop reference wrong");
  AST_OVERDRIVE_LIMIT: assert property (
    closed_loop |=> od_drive_out <= $past(overdrive_limit_reg))
    else $error("overdrive above limit");
  AST_CAL_COMP: assert property (
    cal_res.done |=> calib_loss_compensation_reg ==
      ($past(cal_res.impedance) >> LOSS_SHIFT))
    else $error("compensation not taken from impedance");
  AST_CAL_BEMF: assert property (
    cal_res.done |=> feedback_bemf_level == $past(cal_res.backemf))
    else $error("back-emf result not stored");
  AST_GAIN: assert property (
    $stable(calib_loss_compensation_reg) |=>
      gain_out >= 9'($past(gain_in)) &&
      gain_out <= 9'($past(gain_in)) * 9'h002)
    else $error("compensated gain out of range");

  COV_CAL: cover property (cal_res.done ##1 reg_req.rd);
  COV_CLAMP: cover property (closed_loop && od_request >
    overdrive_limit_reg);
  COV_OPEN: cover property (!closed_loop ##1 closed_loop);
  COV_MID: cover property (audio_level > audio_input_floor &&
    audio_level < audio_input_full_scale_reg);
endmodule : hdlcr_regs
